// ==== bench/nvh_ctrl_monitor.sv ====
/* Checker bound to nvh_ctrl: strobe shape, answer time, sequence order.
   Sees only the controller's ports; bind at the foot. */
module nvh_ctrl_monitor
    import nvh_pkg::*;
#(
    parameter int unsigned POWERUP_WAIT = nvh_pkg::POWERUP_RELOAD_CYC
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic cmd_ready_ff,
    input wire logic rsp_valid_ff,
    input wire logic supply_up_ff,
    input wire logic chip_en_n,
    input wire logic wr_en_n,
    input wire logic [nvh_pkg::ADDR_W-1:0] byte_select_lines
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic [19:0] up_cnt_ff; // Cycles with supply up, saturating
    logic rdy_seen_ff; // Ready seen since supply came up
    logic nv_ff; // Store or recall in flight
    logic st_ff; // That command is a store
    logic [2:0] idx_ff; // Strobes issued so far in the sequence
    wire take_nv = cmd_valid && cmd_ready_ff && cmd_op[1];
    wire [19:0] up_max = 20'(POWERUP_WAIT + 8);
    wire [19:0] nxt_up_cnt = !supply_up_ff ? 20'h0 :
        up_cnt_ff + 20'(up_cnt_ff < up_max);
    // Supply loss drops a waiting command with no answer
    wire nxt_nv = take_nv || (nv_ff && !rsp_valid_ff && supply_up_ff);
    // Address the next strobe must carry
    wire [13:0] want = idx_ff == 3'h0 ? SEQ_ADDR_0 :
        idx_ff == 3'h1 ? SEQ_ADDR_1 : idx_ff == 3'h2 ? SEQ_ADDR_2 :
        idx_ff == 3'h3 ? SEQ_ADDR_3 : idx_ff == 3'h4 ? SEQ_ADDR_4 :
        st_ff ? SEQ_STORE_LAST : SEQ_RECALL_LAST;

    // Helper flops, reset with the design
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt_ff <= 20'h0;
            rdy_seen_ff <= 1'b0;
            nv_ff <= 1'b0;
            st_ff <= 1'b0;
            idx_ff <= 3'h0;
        end else begin
            up_cnt_ff <= nxt_up_cnt;
            rdy_seen_ff <= supply_up_ff && (rdy_seen_ff || cmd_ready_ff);
            nv_ff <= nxt_nv;
            st_ff <= take_nv ? !cmd_op[0] : st_ff;
            idx_ff <= take_nv ? 3'h0 : idx_ff + 3'(nv_ff && $fell(chip_en_n));
        end
    end

    // Five low cycles with the address held, then high
    sequence ce_pulse_s;
        (!chip_en_n && $stable(byte_select_lines)) [*5] ##1 chip_en_n;
    endsequence
    sequence answer_s;
        ##[9:11] rsp_valid_ff;
    endsequence

    strobe_shape_a:
        assert property ($fell(chip_en_n) |-> ce_pulse_s)
        else $error("chip enable pulse shape wrong");
    plain_answer_a:
        assert property (cmd_valid && cmd_ready_ff && !cmd_op[1] |-> answer_s)
        else $error("read or write answer late");
    nv_reads_a:
        assert property (nv_ff |-> wr_en_n)
        else $error("write strobe inside command sequence");
    seq_order_a:
        assert property (nv_ff && $fell(chip_en_n) |->
            idx_ff != 3'h6 && byte_select_lines == {1'b0, want})
        else $error("sequence address out of order");
    low_supply_a:
        assert property (!supply_up_ff && !$past(supply_up_ff) |-> !cmd_ready_ff)
        else $error("ready while supply low");
    pu_wait_a:
        assert property (cmd_ready_ff |-> up_cnt_ff >= 20'(POWERUP_WAIT))
        else $error("ready before power-up wait");
    pu_bound_a:
        assert property (up_cnt_ff == up_max |-> rdy_seen_ff)
        else $error("ready too late after power-up");
    no_early_a:
        assert property (!rdy_seen_ff |-> chip_en_n)
        else $error("access during power-up wait");
endmodule
bind nvh_ctrl nvh_ctrl_monitor #(.POWERUP_WAIT(POWERUP_WAIT))
    nvh_ctrl_monitor_inst (.mclk, .sys_rst, .cmd_valid, .cmd_op,
    .cmd_ready_ff, .rsp_valid_ff, .supply_up_ff, .chip_en_n, .wr_en_n,
    .byte_select_lines);

// ==== bench/nvh_sram_model.sv ====
/* Behavioural byte-wide SRAM with a shadow array, far side of nvh_ctrl.
   Assumes the bench resolves the shared data lines. */
module nvh_sram_model
    import nvh_pkg::*;
#(
    parameter int unsigned RECALL_NS = 150,
    parameter int unsigned STORE_NS = 400,
    parameter int unsigned PU_NS = 300
)
(
    input wire logic supply_ok,
    input wire logic chip_en_n,
    input wire logic wr_en_n,
    input wire logic out_en_n,
    input wire logic [nvh_pkg::ADDR_W-1:0] byte_select_lines,
    input wire logic [nvh_pkg::DATA_W-1:0] byte_lines,
    output logic [nvh_pkg::DATA_W-1:0] dev_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sram [0:32767]; // Working array
    logic [7:0] shadow [0:32767]; // Nonvolatile image
    logic [2:0] step = 3'h0; // Sequence reads matched
    logic busy = 1'b0; // Nonvolatile cycle running
    logic pend = 1'b1; // Recall latched from power-up
    logic is_wr; // Access kind, taken just after chip enable falls
    logic [7:0] last = 8'h00; // Last byte read out
    wire [13:0] a14 = byte_select_lines[13:0];
    wire [13:0] want = step == 3'h0 ? SEQ_ADDR_0 : step == 3'h1 ? SEQ_ADDR_1 :
        step == 3'h2 ? SEQ_ADDR_2 : step == 3'h3 ? SEQ_ADDR_3 : SEQ_ADDR_4;

    initial begin
        foreach (shadow[i]) shadow[i] = 8'(i * 7 + 3);
    end
    // Released lines show the inverse of the last byte, never a hold
    assign #(45) dev_q = (!chip_en_n && !out_en_n && wr_en_n && !busy &&
        !pend) ? sram[byte_select_lines] : ~last;
    always @(negedge chip_en_n) #5 is_wr = !wr_en_n;
    // Access ends at chip enable rise; ignored while a cycle runs
    always @(posedge chip_en_n) begin
        if (!busy && !pend) begin
            if (is_wr) begin
                step = 3'h0;
                if (supply_ok) sram[byte_select_lines] = byte_lines;
            end else if (step == 3'h5 && a14 == SEQ_STORE_LAST) begin
                step = 3'h0;
                if (supply_ok) nv_cycle(1'b1, STORE_NS);
            end else if (step == 3'h5 && a14 == SEQ_RECALL_LAST) begin
                step = 3'h0;
                nv_cycle(1'b0, RECALL_NS);
            end else begin
                last = sram[byte_select_lines];
                step = (a14 == want && step != 3'h5) ? step + 3'h1 :
                    3'(a14 == SEQ_ADDR_0);
            end
        end
    end
    always @(negedge supply_ok) pend = 1'b1;
    // Latched recall runs as supply comes back
    always @(posedge supply_ok) begin
        if (pend) begin
            nv_cycle(1'b0, PU_NS);
            if (!chip_en_n && !wr_en_n) sram[byte_select_lines] = ~last;
            pend = 1'b0;
        end
    end
    task automatic nv_cycle(input logic store, input int unsigned ns);
        busy = 1'b1;
        if (store) begin
            shadow = sram;
        end else begin
            foreach (sram[i]) sram[i] = 8'h00;
            sram = shadow;
        end
        #(ns);
        busy = 1'b0;
    endtask
endmodule

// ==== bench/tb_top.sv ====
/* Top bench: nvh_ctrl facing the memory model, random and corner runs.
   Assumes the monitor is bound in and short wait parameters. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvh_pkg::*;
    localparam int unsigned PW = 20; // Short power-up wait
    logic mclk, sys_rst, cmd_valid, supply_ok, cmd_ready_ff, rsp_valid_ff;
    logic supply_up_ff, chip_en_n, wr_en_n, out_en_n, byte_lines_oe;
    logic [1:0] cmd_op;
    logic [14:0] cmd_addr, byte_select_lines;
    logic [7:0] cmd_wdata, rsp_rdata_ff, byte_lines_out, dev_q, d;
    wire [7:0] byte_bus = byte_lines_oe ? byte_lines_out : dev_q; // Wire
    int failures = 0;
    int compares = 0;
    int n;
    logic [7:0] exp_sram [0:32767]; // Expected working array
    logic [7:0] exp_nv [0:32767]; // Expected shadow image
    logic [14:0] wa [0:7]; // Addresses under test

    nvh_ctrl #(.POWERUP_WAIT(PW), .RECALL_WAIT(10), .STORE_WAIT(30))
        nvh_ctrl_inst (.mclk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_wdata, .cmd_ready_ff, .rsp_valid_ff, .rsp_rdata_ff,
        .supply_up_ff, .supply_ok, .chip_en_n, .wr_en_n, .out_en_n,
        .byte_select_lines, .byte_lines_in(byte_bus), .byte_lines_out,
        .byte_lines_oe);
    nvh_sram_model nvh_sram_model_inst (.supply_ok, .chip_en_n, .wr_en_n,
        .out_en_n, .byte_select_lines, .byte_lines(byte_bus), .dev_q);

    function automatic logic [7:0] nv_seed(input int a);
        return 8'(a * 7 + 3);
    endfunction
    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One command; ends at a falling edge with the answer in d
    task automatic do_cmd(input nvh_op_t op, input logic [14:0] a,
            input logic [7:0] wd);
        n = 0;
        while (cmd_ready_ff !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid_ff !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 2000) failures++;
        d = rsp_rdata_ff;
    endtask
    task automatic rd_chk(input logic [14:0] a);
        do_cmd(NVH_OP_READ, a, 8'h00);
        check("read byte", d, exp_sram[a]);
    endtask
    // Supply up, then time the wait until ready
    task automatic power_up();
        supply_ok = 1'b1;
        n = 0;
        while (cmd_ready_ff !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        check("power-up wait", 8'(n >= PW), 8'h1);
        check("power-up bound", 8'(n <= PW + 8), 8'h1);
        check("supply flag up", 8'(supply_up_ff), 8'h1);
        exp_sram = exp_nv;
    endtask
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Hang guard, well past the expected run
    initial begin
        #100us;
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(51330));
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_addr = 15'h0;
        cmd_wdata = 8'h00;
        supply_ok = 1'b0;
        foreach (exp_nv[i]) exp_nv[i] = nv_seed(i);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        check("ready, supply low", 8'(cmd_ready_ff), 8'h0);
        power_up();
        // Random places: reload image, then back-to-back write and read
        for (int i = 0; i < 8; i++) begin
            wa[i] = 15'($urandom);
            rd_chk(wa[i]);
            exp_sram[wa[i]] = 8'($urandom);
            do_cmd(NVH_OP_WRITE, wa[i], exp_sram[wa[i]]);
            check("write answer", d, 8'h00);
            rd_chk(wa[i]);
        end
        do_cmd(NVH_OP_WRITE, 15'h303f, 8'h5c);
        exp_sram[15'h303f] = 8'h5c;
        do_cmd(NVH_OP_STORE, 15'h0, 8'h00);
        check("store answer", d, 8'h5c);
        exp_nv = exp_sram;
        for (int i = 0; i < 8; i++) do_cmd(NVH_OP_WRITE, wa[i], 8'($urandom));
        // Two recalls in a row both bring back the stored image
        for (int k = 0; k < 2; k++) begin
            do_cmd(NVH_OP_RECALL, 15'h0, 8'h00);
            exp_sram = exp_nv;
            check("recall answer", d, 8'h5c);
            for (int i = 0; i < 8; i++) rd_chk(wa[i]);
        end
        // Write then lose supply: the latched recall undoes it
        do_cmd(NVH_OP_WRITE, wa[0], ~exp_sram[wa[0]]);
        supply_ok = 1'b0;
        repeat (8) @(negedge mclk);
        check("ready, supply lost", 8'(cmd_ready_ff), 8'h0);
        check("supply flag down", 8'(supply_up_ff), 8'h0);
        power_up();
        rd_chk(wa[0]);
        close_out();
    end
endmodule

// ==== rtl/nvh_bus_cycle.sv ====
/*
 * One chip-enable-controlled access on the asynchronous SRAM pins: one
 * cycle of address setup, chip enable low for CE_LOW_CYC cycles, then a
 * cycle of data hold. Assumes the byte lines input is already passed
 * through two flip-flops by the caller and that start comes only while
 * the engine is idle.
 */
module nvh_bus_cycle
    import nvh_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic wr,
    input wire logic [nvh_pkg::ADDR_W-1:0] addr,
    input wire logic [nvh_pkg::DATA_W-1:0] wdata,
    input wire logic [nvh_pkg::DATA_W-1:0] byte_lines_in_s,
    output logic done_ff,
    output logic [nvh_pkg::DATA_W-1:0] rdata_ff,
    output logic chip_en_n_ff,
    output logic wr_en_n_ff,
    output logic out_en_n_ff,
    output logic [nvh_pkg::ADDR_W-1:0] byte_select_lines_ff,
    output logic [nvh_pkg::DATA_W-1:0] byte_lines_out_ff,
    output logic byte_lines_oe_ff
);
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_HOLD, CY_END} nvh_cy_t;

    nvh_cy_t state_ff;        // Access phase
    logic [2:0] cnt_ff;       // Cycles left with chip enable low
    logic wr_ff;              // Access direction latched at start
    wire cnt_zero = (cnt_ff == 3'h0);

    // Pin sequencing; strobes always return high before data is released
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= CY_IDLE;
            cnt_ff <= 3'h0;
            wr_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
            chip_en_n_ff <= 1'b1;
            wr_en_n_ff <= 1'b1;
            out_en_n_ff <= 1'b1;
            byte_select_lines_ff <= 15'h0000;
            byte_lines_out_ff <= 8'h00;
            byte_lines_oe_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                CY_IDLE: begin
                    // Address and write data settle before chip enable
                    if (start) begin
                        byte_select_lines_ff <= addr;
                        byte_lines_out_ff <= wdata;
                        byte_lines_oe_ff <= wr;
                        wr_ff <= wr;
                        state_ff <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    // Chip enable falls; write enable only for a write
                    chip_en_n_ff <= 1'b0;
                    wr_en_n_ff <= ~wr_ff;
                    out_en_n_ff <= wr_ff;
                    cnt_ff <= 3'(CE_LOW_CYC - 1);
                    state_ff <= CY_HOLD;
                end
                CY_HOLD: begin
                    if (cnt_zero) begin
                        // Two sync stages already covered in CE_LOW_CYC
                        if (!wr_ff) begin
                            rdata_ff <= byte_lines_in_s;
                        end
                        chip_en_n_ff <= 1'b1;
                        wr_en_n_ff <= 1'b1;
                        out_en_n_ff <= 1'b1;
                        state_ff <= CY_END;
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                CY_END: begin
                    // Data held one cycle past the strobes
                    byte_lines_oe_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= CY_IDLE;
                end
                default: begin
                    state_ff <= CY_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== rtl/nvh_ctrl.sv ====
/*
 * Host-side controller for an asynchronous byte-wide SRAM with a
 * nonvolatile shadow array. Takes read, write, store and recall commands
 * on a valid/ready port and drives the memory pins through one access
 * engine. Assumes supply_ok is a pin from a supply monitor that is high
 * while the memory supply is above its trip level, and that this block is
 * the only master on the memory pins.
 */
// Functional notes
// - Recall follows six reads, last 0x0C63
// - Never write while power-up recall ends
// - Six addresses consecutive, in exact order
// - Write enable high across all six reads
module nvh_ctrl
    import nvh_pkg::*;
#(
    parameter int unsigned POWERUP_WAIT = nvh_pkg::POWERUP_RELOAD_CYC,
    parameter int unsigned RECALL_WAIT = nvh_pkg::SW_RELOAD_CYC,
    parameter int unsigned STORE_WAIT = nvh_pkg::STORE_CYC
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [nvh_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvh_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready_ff,
    output logic rsp_valid_ff,
    output logic [nvh_pkg::DATA_W-1:0] rsp_rdata_ff,
    output logic supply_up_ff,
    input wire logic supply_ok,
    output logic chip_en_n,
    output logic wr_en_n,
    output logic out_en_n,
    output logic [nvh_pkg::ADDR_W-1:0] byte_select_lines,
    input wire logic [nvh_pkg::DATA_W-1:0] byte_lines_in,
    output logic [nvh_pkg::DATA_W-1:0] byte_lines_out,
    output logic byte_lines_oe
);
    import nvh_pkg::*;

    typedef enum logic [2:0] {
        ST_PWR_LOW,    // Supply below trip level
        ST_PWR_WAIT,   // Automatic reload running in the memory
        ST_IDLE,       // Ready for a command
        ST_ACC,        // Plain read or write on the pins
        ST_SEQ,        // Command read sequence in flight
        ST_NV_WAIT     // Store or recall running in the memory
    } nvh_state_t;

    nvh_state_t state_ff;
    nvh_state_t nxt_state;

    // Pin input synchronisers; first stages feed only the second
    logic supply_meta_ff;
    logic supply_sync_ff;
    logic [DATA_W-1:0] dq_meta_ff;
    logic [DATA_W-1:0] dq_sync_ff;

    logic [CNT_W-1:0] wait_ff;       // Down-counter for memory busy times
    logic [2:0] seq_idx_ff;          // Step within the six-read sequence
    logic store_ff;                  // Sequence ends in a store
    logic start_ff;                  // One-cycle kick to the access engine
    logic acc_wr_ff;                 // Access is a write
    logic [ADDR_W-1:0] acc_addr_ff;  // Address for the engine
    logic [DATA_W-1:0] acc_wdata_ff; // Write data for the engine

    logic eng_done;                  // Engine finished an access
    logic [DATA_W-1:0] eng_rdata;    // Byte captured by the engine

    // Command decode
    wire take_cmd = cmd_valid & cmd_ready_ff;
    wire op_write = (cmd_op == NVH_OP_WRITE);
    wire op_store = (cmd_op == NVH_OP_STORE);
    wire op_nv = op_store | (cmd_op == NVH_OP_RECALL);
    wire wait_zero = (wait_ff == CNT_W'(0));
    wire seq_last = (seq_idx_ff == SEQ_LAST_IDX);
    wire supply_low = ~supply_sync_ff;

    // Sequence address table; bit 14 driven low as it is not compared
    wire [13:0] last_addr = store_ff ? SEQ_STORE_LAST :
        SEQ_RECALL_LAST;
    wire [2:0] next_idx = seq_idx_ff + 3'h1;
    wire [13:0] seq_addr =
        (next_idx == 3'h1) ? SEQ_ADDR_1 :
        (next_idx == 3'h2) ? SEQ_ADDR_2 :
        (next_idx == 3'h3) ? SEQ_ADDR_3 :
        (next_idx == 3'h4) ? SEQ_ADDR_4 : last_addr;
    wire [CNT_W-1:0] nv_wait = store_ff ? CNT_W'(STORE_WAIT - 1) :
        CNT_W'(RECALL_WAIT - 1);

    // Pin synchronisers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_meta_ff <= 1'b0;
            supply_sync_ff <= 1'b0;
            dq_meta_ff <= 8'h00;
            dq_sync_ff <= 8'h00;
        end else begin
            supply_meta_ff <= supply_ok;
            supply_sync_ff <= supply_meta_ff;
            dq_meta_ff <= byte_lines_in;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // Next state; a low supply returns to ST_PWR_LOW, except in ST_ACC, ST_SEQ or when a command is taken
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_PWR_LOW: begin
                // Memory has latched its reload request while low
                if (!supply_low) begin
                    nxt_state = ST_PWR_WAIT;
                end
            end
            ST_PWR_WAIT: begin
                if (supply_low) begin
                    nxt_state = ST_PWR_LOW;
                end else if (wait_zero) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // A taken command always runs, or its answer is lost
                if (take_cmd) begin
                    nxt_state = op_nv ? ST_SEQ : ST_ACC;
                end else if (supply_low) begin
                    nxt_state = ST_PWR_LOW;
                end
            end
            ST_ACC: begin
                if (eng_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SEQ: begin
                // Nothing else reaches the pins until the sixth read
                if (eng_done && seq_last) begin
                    nxt_state = ST_NV_WAIT;
                end
            end
            ST_NV_WAIT: begin
                if (supply_low) begin
                    nxt_state = ST_PWR_LOW;
                end else if (wait_zero) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_PWR_LOW;
            end
        endcase
    end

    // State and busy counter; the count restarts on each power-up
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_PWR_LOW;
            wait_ff <= CNT_W'(0);
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_PWR_LOW) begin
                wait_ff <= CNT_W'(POWERUP_WAIT - 1);
            end else if (state_ff == ST_SEQ && nxt_state == ST_NV_WAIT) begin
                wait_ff <= nv_wait;
            end else if (!wait_zero) begin
                wait_ff <= wait_ff - CNT_W'(1);
            end
        end
    end

    // Access requests to the engine
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            start_ff <= 1'b0;
            acc_wr_ff <= 1'b0;
            acc_addr_ff <= 15'h0000;
            acc_wdata_ff <= 8'h00;
            seq_idx_ff <= 3'h0;
            store_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (state_ff == ST_IDLE && nxt_state != ST_IDLE &&
                    nxt_state != ST_PWR_LOW) begin
                start_ff <= 1'b1;
                // Sequence reads never assert write enable
                acc_wr_ff <= op_write & ~op_nv;
                acc_addr_ff <= op_nv ? {1'b0, SEQ_ADDR_0} : cmd_addr;
                acc_wdata_ff <= cmd_wdata;
                seq_idx_ff <= 3'h0;
                store_ff <= op_store;
            end else if (state_ff == ST_SEQ && eng_done && !seq_last) begin
                // Next step follows directly, no other access between
                start_ff <= 1'b1;
                acc_addr_ff <= {1'b0, seq_addr};
                seq_idx_ff <= next_idx;
            end
        end
    end

    // User handshake and answers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= 8'h00;
            supply_up_ff <= 1'b0;
        end else begin
            // Ready only while idle, settled and with supply up
            cmd_ready_ff <= (nxt_state == ST_IDLE) && (state_ff == ST_IDLE)
                && !take_cmd;
            supply_up_ff <= supply_sync_ff;
            rsp_valid_ff <= 1'b0;
            if (state_ff == ST_ACC && eng_done) begin
                rsp_valid_ff <= 1'b1;
                rsp_rdata_ff <= acc_wr_ff ? 8'h00 : eng_rdata;
            end else if (state_ff == ST_NV_WAIT && nxt_state == ST_IDLE) begin
                // Byte from the fifth read kept for inspection
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ST_SEQ && eng_done && !seq_last) begin
                rsp_rdata_ff <= eng_rdata;
            end
        end
    end

    // Pin access engine
    nvh_bus_cycle u_cycle (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(start_ff),
        .wr(acc_wr_ff),
        .addr(acc_addr_ff),
        .wdata(acc_wdata_ff),
        .byte_lines_in_s(dq_sync_ff),
        .done_ff(eng_done),
        .rdata_ff(eng_rdata),
        .chip_en_n_ff(chip_en_n),
        .wr_en_n_ff(wr_en_n),
        .out_en_n_ff(out_en_n),
        .byte_select_lines_ff(byte_select_lines),
        .byte_lines_out_ff(byte_lines_out),
        .byte_lines_oe_ff(byte_lines_oe)
    );
endmodule

// ==== rtl/nvh_pkg.sv ====
/*
 * Shared constants for the host-side controller of a byte-wide SRAM with
 * a nonvolatile shadow array: pin widths, command codes, the six-step
 * command address table and the wait times turned into mclk cycles.
 * Assumes a 50 MHz mclk; every time below is converted at that rate.
 */
package nvh_pkg;

    // Pin and command widths
    localparam int unsigned ADDR_W = 15;      // Byte select lines
    localparam int unsigned CMD_ADDR_W = 14;  // Bits the detector compares
    localparam int unsigned DATA_W = 8;       // Byte lines
    localparam int unsigned CNT_W = 20;       // Wide enough for the store wait
    localparam int unsigned SEQ_LEN = 6;      // Reads in a command sequence

    // Host command codes
    typedef enum logic [1:0] {
        NVH_OP_READ,
        NVH_OP_WRITE,
        NVH_OP_STORE,
        NVH_OP_RECALL
    } nvh_op_t;

    // Command address table, low 14 bits only
    localparam logic [13:0] SEQ_ADDR_0 = 14'h0e38;
    localparam logic [13:0] SEQ_ADDR_1 = 14'h31c7;
    localparam logic [13:0] SEQ_ADDR_2 = 14'h03e0;
    localparam logic [13:0] SEQ_ADDR_3 = 14'h3c1f;
    localparam logic [13:0] SEQ_ADDR_4 = 14'h303f;
    localparam logic [13:0] SEQ_STORE_LAST = 14'h0fc0;
    localparam logic [13:0] SEQ_RECALL_LAST = 14'h0c63;
    localparam logic [2:0] SEQ_LAST_IDX = 3'h5;

    // Clock
    localparam int unsigned CLK_PERIOD_NS = 20;

    // Pin access timing (least times round up)
    localparam int unsigned ACCESS_TIME_NS = 45;
    localparam int unsigned ACCESS_CYC =
        (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CE_LOW_CYC = ACCESS_CYC + SYNC_STAGES;

    // Nonvolatile wait times (host waits at least these)
    localparam int unsigned POWERUP_RELOAD_TIME_US = 550;
    localparam int unsigned POWERUP_RELOAD_CYC =
        (POWERUP_RELOAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SW_RELOAD_TIME_US = 20;
    localparam int unsigned SW_RELOAD_CYC =
        (SW_RELOAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_TIME_MS = 10;
    localparam int unsigned STORE_CYC =
        (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
